// *** src/dci_map.svh ***
// offsets, field positions, reset values and timing counts of the clock and idle control
`ifndef DCI_MAP_SVH
`define DCI_MAP_SVH

`define DCI_CLK_MHZ          200
// clock-mode register fields
`define DCI_CM_PLL_BIT       15
`define DCI_CM_DIV4_BIT      8
`define DCI_CM_SCALE_MSB     5
`define DCI_CM_SCALE_LSB     4
`define DCI_CM_MULT_MSB      3
`define DCI_CM_MULT_LSB      0
`define DCI_CM_RESET         16'h0000
// least reference frequencies for lock, in MHz, per scale step
`define DCI_REF_MIN_INT_MHZ  5
`define DCI_REF_MIN_HALF_MHZ 10
`define DCI_REF_MIN_QTR_MHZ  20
// longest reference period, in system cycles, that still locks
`define DCI_PER_MAX_INT      (`DCI_CLK_MHZ / `DCI_REF_MIN_INT_MHZ)
`define DCI_PER_MAX_HALF     (`DCI_CLK_MHZ / `DCI_REF_MIN_HALF_MHZ)
`define DCI_PER_MAX_QTR      (`DCI_CLK_MHZ / `DCI_REF_MIN_QTR_MHZ)
// wake pulse on external interrupt zero
`define DCI_INT0_PULSE_NS    20
`define DCI_INT0_PULSE_CYC   ((`DCI_INT0_PULSE_NS * `DCI_CLK_MHZ + 999) / 1000)
// host register map
`define DCI_REG_INIT         4'h0
`define DCI_REG_CTRL         4'h1
`define DCI_REG_STAT         4'h2
`define DCI_CTRL_HOLD_BIT    0
`define DCI_CTRL_WAKE_BIT    1
`define DCI_CTRL_PUSH_BIT    2
`define DCI_CTRL_RESET       3'h1
`define DCI_STAT_LOCK_BIT    3
`endif

// *** src/dci_pkg.sv ***
// types shared by both ends of the clock and idle control
package dci_pkg;
    typedef enum logic [2:0] {
        DCI_RUN,
        DCI_IDLE_STATE_ONE,
        DCI_IDLE_STATE_TWO,
        DCI_IDLE_STATE_THREE,
        DCI_HELD
    } dci_power_type;

    typedef enum logic [1:0] {
        DCI_SCALE_INT,
        DCI_SCALE_HALF,
        DCI_SCALE_QTR,
        DCI_SCALE_RSVD
    } dci_scale_type;
endpackage : dci_pkg

// *** src/dci_link_if.sv ***
// link between the host microcontroller end and the signal-processor end
`timescale 1ns/1ps
interface dci_link_if;
    import dci_pkg::*;
    logic                hold_reset;
    logic [15:0]         init_mode;
    logic                int0_pulse;
    logic                cfg_wr;
    logic [15:0]         cfg_mode;
    dci_power_type       power_state;
    logic                pll_locked;
    logic                clock_out;

    modport host_mp (
        output hold_reset, init_mode, int0_pulse, cfg_wr, cfg_mode,
        input  power_state, pll_locked, clock_out
    );
    modport dev_mp (
        input  hold_reset, init_mode, int0_pulse, cfg_wr, cfg_mode,
        output power_state, pll_locked, clock_out
    );
endinterface : dci_link_if

// *** src/dci_sync.sv ***
// two-stage synchroniser for a single pin
`timescale 1ns/1ps
module dci_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // pin and result
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg  <= 1'b0;
            level_out <= 1'b0;
        end else begin
            meta_reg  <= pin_in;
            level_out <= meta_reg;
        end
    end
endmodule : dci_sync

// *** src/dci_device.sv ***
// signal-processor end: clock-mode register, clock generator and idle states
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "dci_map.svh"

// Overview of operation
// - divider mode or multiplying mode, per register
// - multiply reference by n, n/2, n/4
// - software keeps reference fast enough to lock
// - divider mode has no reference limit
// - output follows clock-mode register, rewrites included
// - host sets initial mode, core may change
// - software avoids exceeding maximum subsystem frequency
// - three idle instructions enter three idle states
// - first idle: core stops, peripherals, clock run
// - first idle woken by peripheral interrupts
// - second idle: core, peripherals stop, PLL runs
// - second idle ends on reset or interrupt zero
// - third idle also stops the PLL
// - third idle allows external clock-mode change
// - third idle ends on reset or interrupt zero
// - chip reset holds subsystem in reset
// - clock output toggles whenever PLL active
module dci_device
    import dci_pkg::*;
#(
    parameter logic [15:0] REF_STEP = 16'h0100
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // link to host
    dci_link_if.dev_mp       link,
    // reference pin
    input  wire logic        reference_clock_in,
    // core side
    input  wire logic        idle_req,
    input  wire logic [1:0]  idle_code,
    input  wire logic        periph_irq,
    input  wire logic        core_mode_wr,
    input  wire logic [15:0] core_mode_data,
    // clock enables and status
    output logic             core_clk_en,
    output logic             periph_clk_en,
    output logic             pll_run,
    output logic             subsystem_clock_out,
    output logic [15:0]      clock_mode_register
);
    dci_power_type power_reg;
    dci_power_type power_next;
    logic          ref_sync;
    logic          ref_prev_reg;
    logic          ref_rise;
    logic [7:0]    period_cnt_reg;
    logic [7:0]    period_reg;
    logic [15:0]   phase_reg;
    logic [15:0]   phase_step;
    logic [19:0]   step_wide;
    logic [1:0]    div_cnt_reg;
    logic          locked_next;
    logic [7:0]    per_limit;
    dci_scale_type scale;

    dci_sync u_ref_sync (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .pin_in    (reference_clock_in),
        .level_out (ref_sync)
    );

    assign ref_rise = ref_sync & ~ref_prev_reg;
    assign scale    = dci_scale_type'(clock_mode_register[`DCI_CM_SCALE_MSB:`DCI_CM_SCALE_LSB]);

    // power state sequencing
    always_comb begin
        power_next = power_reg;
        if (link.hold_reset) begin
            power_next = DCI_HELD;
        end else begin
            unique case (power_reg)
                DCI_HELD: power_next = DCI_RUN;
                DCI_RUN: begin
                    if (idle_req) begin
                        unique case (idle_code)
                            2'h1:    power_next = DCI_IDLE_STATE_ONE;
                            2'h2:    power_next = DCI_IDLE_STATE_TWO;
                            2'h3:    power_next = DCI_IDLE_STATE_THREE;
                            default: power_next = DCI_RUN;
                        endcase
                    end
                end
                DCI_IDLE_STATE_ONE: begin
                    if (periph_irq || link.int0_pulse) begin
                        power_next = DCI_RUN;
                    end
                end
                DCI_IDLE_STATE_TWO: begin
                    if (link.int0_pulse) begin
                        power_next = DCI_RUN;
                    end
                end
                DCI_IDLE_STATE_THREE: begin
                    if (link.int0_pulse) begin
                        power_next = DCI_RUN;
                    end
                end
                default: power_next = DCI_HELD;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_reg <= DCI_HELD;
        end else begin
            power_reg <= power_next;
        end
    end

    // clock enables follow the next state so they change with it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_clk_en   <= 1'b0;
            periph_clk_en <= 1'b0;
            pll_run       <= 1'b0;
        end else begin
            core_clk_en   <= (power_next == DCI_RUN);
            periph_clk_en <= (power_next == DCI_RUN) ||
                             (power_next == DCI_IDLE_STATE_ONE);
            pll_run       <= (power_next != DCI_IDLE_STATE_THREE) &&
                             (power_next != DCI_HELD);
        end
    end

    // clock-mode register: host seed on release, core writes when running,
    // host pushes only while the PLL is parked in the third idle state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_mode_register <= `DCI_CM_RESET;
        end else if (power_reg == DCI_HELD) begin
            clock_mode_register <= link.init_mode;
        end else if (power_reg == DCI_IDLE_STATE_THREE && link.cfg_wr) begin
            clock_mode_register <= link.cfg_mode;
        end else if (power_reg == DCI_RUN && core_mode_wr) begin
            clock_mode_register <= core_mode_data;
        end
    end

    // reference period measurement for lock qualification
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_prev_reg   <= 1'b0;
            period_cnt_reg <= 8'h00;
            period_reg     <= 8'h00;
        end else begin
            ref_prev_reg <= ref_sync;
            if (ref_rise) begin
                period_reg     <= period_cnt_reg;
                period_cnt_reg <= 8'h01;
            end else if (period_cnt_reg != 8'hFF) begin
                period_cnt_reg <= period_cnt_reg + 8'h01;
            end
            // a stalled reference must drop lock, not keep the old period
            if (period_cnt_reg == 8'hFF) begin
                period_reg <= 8'h00;
            end
        end
    end

    always_comb begin
        unique case (scale)
            DCI_SCALE_INT:  per_limit = 8'(`DCI_PER_MAX_INT);
            DCI_SCALE_HALF: per_limit = 8'(`DCI_PER_MAX_HALF);
            default:        per_limit = 8'(`DCI_PER_MAX_QTR);
        endcase
        locked_next = pll_run && (period_reg != 8'h00) && (period_reg <= per_limit);
    end

    // multiplying mode: step in quarter units of the reference, n*4, n*2 or n
    always_comb begin
        unique case (scale)
            DCI_SCALE_INT:  step_wide = {4'h0, REF_STEP} * {16'h0000,
                                clock_mode_register[`DCI_CM_MULT_MSB:`DCI_CM_MULT_LSB]};
            DCI_SCALE_HALF: step_wide = ({4'h0, REF_STEP} * {16'h0000,
                                clock_mode_register[`DCI_CM_MULT_MSB:`DCI_CM_MULT_LSB]}) >> 1;
            default:        step_wide = ({4'h0, REF_STEP} * {16'h0000,
                                clock_mode_register[`DCI_CM_MULT_MSB:`DCI_CM_MULT_LSB]}) >> 2;
        endcase
        phase_step = step_wide[15:0];
    end

    // clock generator; the output runs whenever the PLL is up, whatever
    // the core's own clock-output setting says
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg           <= 16'h0000;
            div_cnt_reg         <= 2'h0;
            subsystem_clock_out <= 1'b0;
        end else if (!pll_run) begin
            phase_reg           <= 16'h0000;
            div_cnt_reg         <= 2'h0;
            subsystem_clock_out <= 1'b0;
        end else if (clock_mode_register[`DCI_CM_PLL_BIT]) begin
            phase_reg           <= phase_reg + phase_step;
            subsystem_clock_out <= phase_reg[15];
        end else if (ref_rise) begin
            // divider mode counts reference edges, so any rate works
            div_cnt_reg <= div_cnt_reg + 2'h1;
            if (!clock_mode_register[`DCI_CM_DIV4_BIT] || div_cnt_reg[0]) begin
                subsystem_clock_out <= ~subsystem_clock_out;
            end
        end
    end

    // link status back to host
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            link.power_state <= DCI_HELD;
            link.pll_locked  <= 1'b0;
            link.clock_out   <= 1'b0;
        end else begin
            link.power_state <= power_reg;
            // divider mode needs no lock; multiplying mode checks the limit
            link.pll_locked  <= clock_mode_register[`DCI_CM_PLL_BIT] ?
                                locked_next : pll_run;
            link.clock_out   <= subsystem_clock_out;
        end
    end
endmodule : dci_device

// *** src/dci_host.sv ***
// host microcontroller end: initial mode, reset hold, wake pulse, mode push
`timescale 1ns/1ps
`include "dci_map.svh"
module dci_host
    import dci_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    // link to device
    dci_link_if.host_mp      link
);
    logic [15:0] sub_clock_mode_register;
    logic        hold_reg;
    logic [3:0]  pulse_cnt_reg;
    logic        ctrl_wr;

    assign ctrl_wr = reg_wr && (reg_addr == `DCI_REG_CTRL);

    // initial setting seeded into the device on each reset release
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sub_clock_mode_register <= `DCI_CM_RESET;
        end else if (reg_wr && reg_addr == `DCI_REG_INIT) begin
            sub_clock_mode_register <= reg_wdata;
        end
    end

    // chip reset leaves the subsystem held until software releases it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg <= 1'(`DCI_CTRL_RESET);
        end else if (ctrl_wr) begin
            hold_reg <= reg_wdata[`DCI_CTRL_HOLD_BIT];
        end
    end

    // wake pulse of fixed width on external interrupt zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_cnt_reg <= 4'h0;
        end else if (ctrl_wr && reg_wdata[`DCI_CTRL_WAKE_BIT]) begin
            pulse_cnt_reg <= 4'(`DCI_INT0_PULSE_CYC);
        end else if (pulse_cnt_reg != 4'h0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            link.hold_reset <= 1'b1;
            link.init_mode  <= `DCI_CM_RESET;
            link.int0_pulse <= 1'b0;
            link.cfg_wr     <= 1'b0;
            link.cfg_mode   <= `DCI_CM_RESET;
        end else begin
            link.hold_reset <= hold_reg;
            link.init_mode  <= sub_clock_mode_register;
            link.int0_pulse <= (pulse_cnt_reg != 4'h0);
            // push is honoured by the device only in the third idle state
            link.cfg_wr     <= ctrl_wr && reg_wdata[`DCI_CTRL_PUSH_BIT];
            link.cfg_mode   <= sub_clock_mode_register;
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `DCI_REG_INIT: reg_rdata <= sub_clock_mode_register;
                `DCI_REG_CTRL: reg_rdata <= {15'h0000, hold_reg};
                `DCI_REG_STAT: reg_rdata <= {12'h000, link.pll_locked,
                                             link.power_state};
                default:       reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : dci_host

// *** tb/dci_link_chk.sv ***
// assertions on the link between the host end and the device end
`timescale 1ns/1ps
module dci_link_chk
    import dci_pkg::*;
(
    // clock and reset
    input wire logic     sys_clk,
    input wire logic     arst_n,
    // host to device
    input wire logic     hold_reset,
    input wire logic     int0_pulse,
    input wire logic     cfg_wr,
    // device to host
    input dci_power_type power_state,
    input wire logic     pll_locked,
    input wire logic     clock_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // status lags the device state by one cycle, hence the two-cycle offsets
    property p_hold_state;
        hold_reset |-> ##2 (power_state == DCI_HELD);
    endproperty
    a_hold_state: assert property (p_hold_state)
        else $error("held reset not reported as held");

    property p_release;
        $fell(hold_reset) |-> ##2 (power_state == DCI_RUN);
    endproperty
    a_release: assert property (p_release)
        else $error("release did not start the core");

    property p_idle_state_two_exit;
        $fell(power_state == DCI_IDLE_STATE_TWO) |-> $past(int0_pulse, 2) || $past(hold_reset, 2);
    endproperty
    a_idle_state_two_exit: assert property (p_idle_state_two_exit)
        else $error("second idle left without wake or reset");

    property p_idle_state_three_exit;
        $fell(power_state == DCI_IDLE_STATE_THREE) |-> $past(int0_pulse, 2) || $past(hold_reset, 2);
    endproperty
    a_idle_state_three_exit: assert property (p_idle_state_three_exit)
        else $error("third idle left without wake or reset");

    property p_wake;
        $rose(int0_pulse) && (power_state == DCI_IDLE_STATE_TWO || power_state == DCI_IDLE_STATE_THREE)
            |-> ##2 (power_state == DCI_RUN);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake pulse did not resume the core");

    property p_idle_state_three_lock;
        (power_state == DCI_IDLE_STATE_THREE) [*2] |-> !pll_locked;
    endproperty
    a_idle_state_three_lock: assert property (p_idle_state_three_lock)
        else $error("loop reported locked while stopped");

    property p_idle_state_three_clk;
        (power_state == DCI_IDLE_STATE_THREE) [*2] |-> !clock_out;
    endproperty
    a_idle_state_three_clk: assert property (p_idle_state_three_clk)
        else $error("clock output moving while loop stopped");

    property p_int0_width;
        $rose(int0_pulse) |-> int0_pulse [*4] ##1 !int0_pulse;
    endproperty
    a_int0_width: assert property (p_int0_width)
        else $error("wake pulse width wrong");

    property p_push_pulse;
        cfg_wr |=> !cfg_wr;
    endproperty
    a_push_pulse: assert property (p_push_pulse)
        else $error("mode push longer than one cycle");
endmodule : dci_link_chk

// *** tb/dsp_clock_and_idle_control_test.sv ***
// self-checking bench for the clock and idle control, both ends joined
`timescale 1ns/1ps
`include "dci_map.svh"
module dsp_clock_and_idle_control_test;
    logic        sys_clk, arst_n, reg_wr, reg_rd, reference_clock_in;
    logic        idle_req, periph_irq, core_mode_wr;
    logic        core_clk_en, periph_clk_en, pll_run, subsystem_clock_out;
    logic [1:0]  idle_code;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, core_mode_data, clock_mode_register, rd;
    int          num_errors, check_count, cycle_count, ref_half, ref_cnt, e0, e1, e2, e3;

    dci_link_if link ();
    dci_host dci_host_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
    dci_device dci_device_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .link(link),
        .reference_clock_in(reference_clock_in), .idle_req(idle_req), .idle_code(idle_code),
        .periph_irq(periph_irq), .core_mode_wr(core_mode_wr), .core_mode_data(core_mode_data),
        .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .pll_run(pll_run),
        .subsystem_clock_out(subsystem_clock_out), .clock_mode_register(clock_mode_register));
    dci_link_chk dci_link_chk_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .hold_reset(link.hold_reset),
        .int0_pulse(link.int0_pulse), .cfg_wr(link.cfg_wr), .power_state(link.power_state),
        .pll_locked(link.pll_locked), .clock_out(link.clock_out));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // reference pin period is 2*ref_half system cycles; the run ends well before 20000
    always @(posedge sys_clk) begin
        ref_cnt <= (ref_cnt >= ref_half - 1) ? 0 : ref_cnt + 1;
        if (ref_cnt >= ref_half - 1) reference_clock_in <= ~reference_clock_in;
        cycle_count <= cycle_count + 1;
        if (cycle_count == 20000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_en(input logic [2:0] exp);
        check_word("core periph pll enables", {13'h0000, exp},
                   {13'h0000, core_clk_en, periph_clk_en, pll_run});
    endtask : check_en

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic check_stat(input logic [15:0] exp);
        reg_read(`DCI_REG_STAT, rd);
        check_word("status", exp, rd);
    endtask : check_stat

    task automatic core_idle(input logic [1:0] c);
        @(posedge sys_clk);
        idle_req  <= 1'b1;
        idle_code <= c;
        @(posedge sys_clk);
        idle_req <= 1'b0;
        #1;
    endtask : core_idle

    task automatic core_write(input logic [15:0] d);
        @(posedge sys_clk);
        core_mode_wr   <= 1'b1;
        core_mode_data <= d;
        @(posedge sys_clk);
        core_mode_wr <= 1'b0;
        step(2);
    endtask : core_write

    // count output edges over n cycles
    task automatic edge_count(input int n, output int t);
        logic last;
        t    = 0;
        last = subsystem_clock_out;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            if (subsystem_clock_out !== last) t++;
            last = subsystem_clock_out;
        end
    endtask : edge_count

    // edge alignment allows one either way
    task automatic clock_count(input int n, input int lo, input int hi);
        int t;
        edge_count(n, t);
        check_word("clock edges in range", 16'h0001, {15'h0000, t >= lo && t <= hi});
    endtask : clock_count

    task automatic irq_pulse;
        @(posedge sys_clk);
        periph_irq <= 1'b1;
        repeat (3) @(posedge sys_clk);
        periph_irq <= 1'b0;
        #1;
    endtask : irq_pulse

    initial begin
        arst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
        reference_clock_in = 1'b0; idle_req = 1'b0; idle_code = 2'h0; periph_irq = 1'b0;
        core_mode_wr = 1'b0; core_mode_data = 16'h0000;
        num_errors = 0; check_count = 0; cycle_count = 0; ref_half = 4; ref_cnt = 0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        step(2);
        check_en(3'h0);
        check_stat(16'h0004);
        reg_read(4'hF, rd);
        check_word("unmapped read", 16'h0000, rd);
        reg_write(`DCI_REG_INIT, 16'h8013);
        reg_write(`DCI_REG_CTRL, 16'h0000);
        step(2);
        check_word("mode after release", 16'h8013, clock_mode_register);
        check_en(3'h7);
        step(100);
        check_stat(16'h0008);
        // one k from n, n/2 and n/4 gives one rate; doubling k doubles it
        core_write(16'h8002);
        edge_count(512, e0);
        core_write(16'h8004);
        edge_count(512, e3);
        core_write(16'h8014);
        edge_count(512, e1);
        core_write(16'h8028);
        edge_count(512, e2);
        check_word("loop output running", 16'h0001, {15'h0000, e0 > 0});
        check_word("double multiplier rate", 16'(2 * e0), 16'(e3));
        check_word("half step rate", 16'(e0), 16'(e1));
        check_word("quarter step rate", 16'(e0), 16'(e2));
        // 16-cycle reference: integer and half steps lock, quarter steps do not
        ref_half = 8;
        for (int s = 0; s < 3; s++) begin
            core_write(16'h8005 | (16'(s) << 4));
            step(120);
            check_stat({12'h000, s != 2, 3'h0});
        end
        ref_half = 50;
        core_write(16'h0000);
        step(250);
        check_stat(16'h0008);
        core_write(16'h8005);
        step(250);
        check_stat(16'h0000);
        ref_half = 4;
        core_write(16'h0000);
        check_word("core mode write", 16'h0000, clock_mode_register);
        clock_count(128, 15, 17);
        core_write(16'h0100);
        clock_count(128, 7, 9);
        core_idle(2'h0);
        check_en(3'h7);
        core_idle(2'h1);
        check_en(3'h3);
        clock_count(128, 7, 9);
        check_stat(16'h0009);
        irq_pulse();
        check_en(3'h7);
        core_idle(2'h2);
        check_en(3'h1);
        irq_pulse();
        check_en(3'h1);
        check_stat(16'h000A);
        reg_write(`DCI_REG_CTRL, 16'h0002);
        step(3);
        check_en(3'h7);
        core_idle(2'h3);
        check_en(3'h0);
        clock_count(64, 0, 0);
        check_stat(16'h0003);
        reg_write(`DCI_REG_INIT, 16'h0000);
        reg_write(`DCI_REG_CTRL, 16'h0004);
        step(3);
        check_word("mode pushed while stopped", 16'h0000, clock_mode_register);
        check_en(3'h0);
        reg_write(`DCI_REG_CTRL, 16'h0002);
        step(3);
        check_en(3'h7);
        clock_count(128, 15, 17);
        reg_write(`DCI_REG_INIT, 16'h0100);
        reg_write(`DCI_REG_CTRL, 16'h0004);
        step(3);
        check_word("push refused while running", 16'h0000, clock_mode_register);
        core_idle(2'h2);
        reg_write(`DCI_REG_INIT, 16'h8013);
        reg_write(`DCI_REG_CTRL, 16'h0001);
        step(3);
        check_en(3'h0);
        check_stat(16'h0004);
        reg_write(`DCI_REG_CTRL, 16'h0000);
        step(2);
        check_word("mode after second release", 16'h8013, clock_mode_register);
        check_en(3'h7);
        final_report();
    end
endmodule : dsp_clock_and_idle_control_test
